/* rtl/dif_pkg.sv */
/*
  shared constants and carrier structs for the digital input function decoder.
  assumes a single 25 MHz clock and a classic wishbone register slave.
*/
package dif_pkg;
  // terminal count and function code width
  localparam int DIF_NTERM = 8;
  localparam int DIF_CODE_W = 8;
  // function codes
  localparam logic [7:0] FN_PID_IRST = 8'h30;
  localparam logic [7:0] FN_PID_IHOLD = 8'h31;
  localparam logic [7:0] FN_STEP4 = 8'h32;
  localparam logic [7:0] FN_SOFT_CAN = 8'h34;
  localparam logic [7:0] FN_PID_SIGN = 8'h35;
  localparam logic [7:0] FN_FWD2W = 8'h40;
  localparam logic [7:0] FN_REV2W = 8'h41;
  localparam logic [7:0] FN_RUN2W = 8'h42;
  localparam logic [7:0] FN_DIR2W = 8'h43;
  localparam logic [7:0] FN_OFS1 = 8'h44;
  localparam logic [7:0] FN_OFS2 = 8'h45;
  localparam logic [7:0] FN_OFS3 = 8'h46;
  localparam logic [7:0] FN_DCBRK = 8'h60;
  localparam logic [7:0] FN_SRCH1 = 8'h61;
  localparam logic [7:0] FN_SRCH2 = 8'h62;
  localparam logic [7:0] FN_KEB_NC = 8'h65;
  localparam logic [7:0] FN_KEB_NO = 8'h66;
  localparam logic [7:0] FN_COMTEST = 8'h67;
  localparam logic [7:0] FN_ENABLE = 8'h6A;
  localparam logic [7:0] FN_TRQSW = 8'h71;
  localparam logic [7:0] FN_BIAS_UP = 8'h75;
  localparam logic [7:0] FN_BIAS_DN = 8'h76;
  // register word offsets (byte addresses)
  localparam logic [7:0] DIF_FSEL_LO = 8'h00;
  localparam logic [7:0] DIF_FSEL_HI = 8'h04;
  localparam logic [7:0] DIF_CTRL = 8'h08;
  localparam logic [7:0] DIF_CMD = 8'h0C;
  localparam logic [7:0] DIF_STAT = 8'h10;
  localparam logic [7:0] DIF_LOOP = 8'h14;
  // reset values
  localparam logic [31:0] DIF_FSEL_RST = 32'h0000_0000;
  localparam logic [31:0] DIF_CTRL_RST = 32'h0000_0000;
  // ctrl field positions
  localparam int CTRL_STOP_LSB = 0;
  localparam int CTRL_MODE_LSB = 2;
  localparam int CTRL_SRCH_BIT = 4;
  localparam int CTRL_EFCLR_BIT = 5;
  // serial test: reset pattern, cycles per bit and timeout cycles
  localparam logic [7:0] DIF_LOOP_PAT_RST = 8'hA5;
  localparam int DIF_BIT_CYC = 16;
  localparam int DIF_TEST_TMO = 64;

  // decoded terminal functions
  typedef struct packed {
    logic pid_irst;
    logic pid_ihold;
    logic step4;
    logic soft_can;
    logic pid_sign;
    logic fwd;
    logic rev;
    logic run2;
    logic dir2;
    logic [2:0] ofs;
    logic dcbrk;
    logic srch;
    logic kinetic_buffer_decel;
    logic comtest;
    logic enable;
    logic trq;
    logic bias_up;
    logic bias_dn;
  } dif_func_t;

  // which codes are assigned at all
  typedef struct packed {
    logic fwdrev;
    logic rundir;
    logic srch1;
    logic srch2;
    logic keb_nc;
    logic keb_no;
    logic enable;
    logic trq;
    logic bias_up;
    logic bias_dn;
  } dif_asg_t;

  // serial test states, gray along idle-send-check-done
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_CHECK = 2'b11,
    ST_DONE = 2'b10
  } dif_st_t;
endpackage

/* rtl/dif_loop_test.sv */
/*
  serial loopback self test: shifts a byte out and checks it comes back.
  assumes the partner wires tx to rx; rx arrives already synchronised.
*/
`timescale 1ns/100ps
module dif_loop_test
  import dif_pkg::*;
(
  input wire logic clk_i, // system clock
  input wire logic rst_i, // sync reset
  input wire logic start_i, // test request level
  input wire logic [7:0] pat_i, // byte to send
  input wire logic rx_i, // looped receive line, synchronised
  output logic tx_o, // transmit line
  output logic busy_o, // test running
  output logic pass_o, // last test passed
  output logic fail_o // last test failed
);
  dif_st_t st_reg; // sequencer state
  logic [7:0] sh_reg; // transmit shifter
  logic [7:0] rx_reg; // received bits
  logic [3:0] bit_reg; // bit index, 8 data plus start
  logic [7:0] cyc_reg; // cycles within a bit
  logic start_d_reg; // edge detect on request

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= ST_IDLE;
      sh_reg <= 8'h00;
      rx_reg <= 8'h00;
      bit_reg <= 4'h0;
      cyc_reg <= 8'h00;
      tx_o <= 1'b1;
      pass_o <= 1'b0;
      fail_o <= 1'b0;
      start_d_reg <= 1'b0;
    end else begin
      start_d_reg <= start_i;
      unique case (st_reg)
        ST_IDLE: begin
          // new test only on a rising request
          if (start_i && !start_d_reg) begin
            st_reg <= ST_SEND;
            sh_reg <= pat_i;
            bit_reg <= 4'h0;
            cyc_reg <= 8'h00;
            tx_o <= 1'b0; // start bit
            pass_o <= 1'b0;
            fail_o <= 1'b0;
          end
        end
        ST_SEND: begin
          if (cyc_reg == 8'(DIF_BIT_CYC - 1)) begin
            cyc_reg <= 8'h00;
            tx_o <= sh_reg[0];
            sh_reg <= {1'b1, sh_reg[7:1]};
            bit_reg <= bit_reg + 4'h1;
            if (bit_reg == 4'h8) begin
              tx_o <= 1'b1; // stop level
              st_reg <= ST_CHECK;
            end
          end else begin
            cyc_reg <= cyc_reg + 8'h01;
          end
          // sample mid bit, data bits only
          if (cyc_reg == 8'(DIF_BIT_CYC / 2) && bit_reg != 4'h0) begin
            rx_reg <= {rx_i, rx_reg[7:1]};
          end
        end
        ST_CHECK: begin
          st_reg <= ST_DONE;
          pass_o <= (rx_reg == pat_i);
          fail_o <= (rx_reg != pat_i);
        end
        ST_DONE: begin
          // wait for the request to drop before rearming
          if (!start_i) begin
            st_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  assign busy_o = (st_reg == ST_SEND) || (st_reg == ST_CHECK);
endmodule

/* rtl/dif_decoder.sv */
/*
  digital input function decoder: synchronises terminals, decodes function codes,
  checks assignments and drives run, brake, pid and mode commands.
  assumes a classic wishbone master and terminal pins asynchronous to clk_i.
*/
// The address map and the Wishbone interface to the registers were left to the implementer.
// Functional notes
// - code 30 closed zeroes pid integral
// - code 31 freezes integral, resumes on release
// - code 32 is fourth speed select bit
// - code 34 cancels pid soft starter
// - code 35 inverts pid input sign
// - codes 40/41 run forward or reverse
// - both 40 and 41 closed: external fault
// - 40/41 with 42/43 is rejected
// - code 42 runs while closed
// - code 43 open forward, closed reverse
// - codes 44-46 add offset frequencies
// - code 60 brakes only while stopped
// - codes 61/62 force speed search enable
// - both search inputs assigned: conflict error
// - 65 closed normal; 66 closed decelerates
// - both ride-through inputs assigned: conflict error
// - code 67 runs serial loopback test
// - code 6A open refuses run, shows disabled
// - run held at enable needs recycling
// - enable opening while running stops drive
// - code 71 closed torque, mode setting zero
// - codes 75/76 bias, must be paired
// - external fault stops the drive
`timescale 1ns/100ps
module dif_decoder
  import dif_pkg::*;
#(
  parameter int NTERM = DIF_NTERM // number of input terminals
) (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // sync reset, active high
  input wire logic [NTERM-1:0] term_i, // terminal levels, 1 = closed
  input wire logic rx_i, // serial receive line
  input wire logic [7:0] wb_adr_i, // wishbone byte address
  input wire logic [31:0] wb_dat_i, // wishbone write data
  input wire logic [3:0] wb_sel_i, // wishbone byte lanes
  input wire logic wb_we_i, // wishbone write
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone ack
  output logic run_fwd_o, // motor runs forward
  output logic run_rev_o, // motor runs reverse
  output logic stop_req_o, // stop with configured method
  output logic [1:0] stop_method_o, // stop method select
  output logic ext_fault_o, // external fault latched
  output logic setting_conflict_error_o, // bad assignment
  output logic drive_disabled_indication_o, // enable open
  output logic pid_int_reset_o, // force integral to zero
  output logic pid_int_hold_o, // freeze integral
  output logic pid_soft_cancel_o, // bypass pid_ramp_time
  output logic pid_sign_inv_o, // invert pid input
  output logic step_sel4_o, // fourth speed select bit
  output logic [2:0] offset_sel_o, // offset frequency 1..3 adds
  output logic dc_brake_o, // dc injection braking
  output logic search_en_o, // speed search enabled
  output logic kinetic_buffer_decel_o, // ride-through decel
  output logic torque_mode_o, // torque control selected
  output logic bias_up_o, // raise frequency bias
  output logic bias_dn_o, // lower frequency bias
  output logic tx_o // serial transmit line
);
  logic [NTERM-1:0] sync1_reg; // first sync stage
  logic [NTERM-1:0] term_reg; // synchronised terminals
  logic rx1_reg; // rx first stage
  logic rx_reg; // rx second stage
  logic [7:0] fsel_reg [NTERM]; // input_function_select per terminal
  logic [31:0] ctrl_reg; // stop method, mode, search flag
  logic [1:0] cmd_reg; // software run (forward only) and jog
  logic [7:0] pat_reg; // loopback pattern
  logic run_armed_reg; // run may start after enable
  logic running_reg; // drive currently running
  logic en_d_reg; // enable level last cycle
  logic any_run_d_reg; // run request last cycle
  dif_func_t fn; // decoded closed functions
  dif_asg_t asg; // assigned codes
  logic conflict; // any bad assignment
  logic any_run; // run request from the selected source: 42/43, else 40/41, else software run
  logic dir_rev; // requested direction
  logic enabled; // drive enable state
  logic jog; // software jog
  logic lt_busy, lt_pass, lt_fail, lt_tx; // loop test outputs
  logic wb_hit; // request seen this cycle

  // true if any terminal carries the code
  function automatic logic has_code(input logic [7:0] code);
    logic r;
    r = 1'b0;
    for (int i = 0; i < NTERM; i++) begin
      r = r | (fsel_reg[i] == code);
    end
    return r;
  endfunction

  // true if a terminal with the code is closed
  function automatic logic closed_code(input logic [7:0] code);
    logic r;
    r = 1'b0;
    for (int i = 0; i < NTERM; i++) begin
      r = r | ((fsel_reg[i] == code) & term_reg[i]);
    end
    return r;
  endfunction

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg <= '0;
      term_reg <= '0;
      rx1_reg <= 1'b1;
      rx_reg <= 1'b1;
    end else begin
      sync1_reg <= term_i;
      term_reg <= sync1_reg;
      rx1_reg <= rx_i;
      rx_reg <= rx1_reg;
    end
  end

  // decode from the synchronised sample only
  always_comb begin
    fn.pid_irst = closed_code(FN_PID_IRST);
    fn.pid_ihold = closed_code(FN_PID_IHOLD);
    fn.step4 = closed_code(FN_STEP4);
    fn.soft_can = closed_code(FN_SOFT_CAN);
    fn.pid_sign = closed_code(FN_PID_SIGN);
    fn.fwd = closed_code(FN_FWD2W);
    fn.rev = closed_code(FN_REV2W);
    fn.run2 = closed_code(FN_RUN2W);
    fn.dir2 = closed_code(FN_DIR2W);
    fn.ofs = {closed_code(FN_OFS3), closed_code(FN_OFS2), closed_code(FN_OFS1)};
    fn.dcbrk = closed_code(FN_DCBRK);
    fn.srch = closed_code(FN_SRCH1) | closed_code(FN_SRCH2);
    // nc opens to decel, no closes to decel
    fn.kinetic_buffer_decel = (has_code(FN_KEB_NC) & ~closed_code(FN_KEB_NC)) | closed_code(FN_KEB_NO);
    fn.comtest = closed_code(FN_COMTEST);
    fn.enable = closed_code(FN_ENABLE);
    fn.trq = closed_code(FN_TRQSW);
    fn.bias_up = closed_code(FN_BIAS_UP);
    fn.bias_dn = closed_code(FN_BIAS_DN);
  end

  // assignment summary
  always_comb begin
    asg.fwdrev = has_code(FN_FWD2W) | has_code(FN_REV2W);
    asg.rundir = has_code(FN_RUN2W) | has_code(FN_DIR2W);
    asg.srch1 = has_code(FN_SRCH1);
    asg.srch2 = has_code(FN_SRCH2);
    asg.keb_nc = has_code(FN_KEB_NC);
    asg.keb_no = has_code(FN_KEB_NO);
    asg.enable = has_code(FN_ENABLE);
    asg.trq = has_code(FN_TRQSW);
    asg.bias_up = has_code(FN_BIAS_UP);
    asg.bias_dn = has_code(FN_BIAS_DN);
  end

  // conflict checks; torque switch needs mode 0
  assign conflict = (asg.fwdrev & asg.rundir) | (asg.srch1 & asg.srch2) |
                    (asg.keb_nc & asg.keb_no) | (asg.bias_up ^ asg.bias_dn) |
                    (asg.trq & (ctrl_reg[CTRL_MODE_LSB +: 2] != 2'b00));

  // run request and direction from the active sequence
  always_comb begin
    jog = cmd_reg[1];
    any_run = 1'b0;
    dir_rev = 1'b0;
    if (asg.rundir) begin
      // run while closed, 43 picks direction
      any_run = fn.run2;
      dir_rev = fn.dir2;
    end else if (asg.fwdrev) begin
      any_run = fn.fwd ^ fn.rev;
      dir_rev = fn.rev;
    end else begin
      any_run = cmd_reg[0];
      dir_rev = 1'b0;
    end
    enabled = ~asg.enable | fn.enable;
  end

  // register slave, one wait-free cycle, ack dropped after one
  assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  // wishbone ack and read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_hit;
      if (wb_hit && !wb_we_i) begin
        unique case (wb_adr_i)
          DIF_FSEL_LO: wb_dat_o <= {fsel_reg[3], fsel_reg[2], fsel_reg[1], fsel_reg[0]};
          DIF_FSEL_HI: wb_dat_o <= {fsel_reg[7], fsel_reg[6], fsel_reg[5], fsel_reg[4]};
          DIF_CTRL: wb_dat_o <= ctrl_reg;
          DIF_CMD: wb_dat_o <= {30'h0, cmd_reg};
          DIF_STAT: wb_dat_o <= {16'h0, lt_fail, lt_pass, lt_busy, running_reg,
                                 ext_fault_o, setting_conflict_error_o,
                                 drive_disabled_indication_o, 1'b0, term_reg};
          DIF_LOOP: wb_dat_o <= {24'h0, pat_reg};
          default: wb_dat_o <= 32'h0000_0000; // unmapped reads zero
        endcase
      end
    end
  end

  // writable registers, byte lanes honoured
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NTERM; i++) begin
        fsel_reg[i] <= DIF_FSEL_RST[7:0];
      end
      ctrl_reg <= DIF_CTRL_RST;
      cmd_reg <= 2'b00;
      pat_reg <= DIF_LOOP_PAT_RST;
    end else if (wb_hit && wb_we_i) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b]) begin
          if (wb_adr_i == DIF_FSEL_LO) fsel_reg[b] <= wb_dat_i[8*b +: 8];
          if (wb_adr_i == DIF_FSEL_HI) fsel_reg[b+4] <= wb_dat_i[8*b +: 8];
          if (wb_adr_i == DIF_CTRL) ctrl_reg[8*b +: 8] <= wb_dat_i[8*b +: 8];
        end
      end
      if (wb_adr_i == DIF_CMD && wb_sel_i[0]) cmd_reg <= wb_dat_i[1:0];
      if (wb_adr_i == DIF_LOOP && wb_sel_i[0]) pat_reg <= wb_dat_i[7:0];
    end else begin
      // fault clear bit is self clearing
      ctrl_reg[CTRL_EFCLR_BIT] <= 1'b0;
    end
  end

  // external fault, set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_fault_o <= 1'b0;
    end else if (asg.fwdrev && !asg.rundir && fn.fwd && fn.rev) begin
      ext_fault_o <= 1'b1;
    end else if (ctrl_reg[CTRL_EFCLR_BIT]) begin
      ext_fault_o <= 1'b0;
    end
  end

  // run arming and state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_armed_reg <= 1'b0;
      running_reg <= 1'b0;
      en_d_reg <= 1'b0;
      any_run_d_reg <= 1'b0;
    end else begin
      en_d_reg <= enabled;
      any_run_d_reg <= any_run;
      // run seen released while enabled arms
      if (!enabled) begin
        run_armed_reg <= 1'b0;
      end else if (!any_run) begin
        run_armed_reg <= 1'b1;
      end
      // stop on open enable or fault
      if (!enabled || ext_fault_o || conflict || !any_run) begin
        running_reg <= 1'b0;
      end else if (run_armed_reg) begin
        running_reg <= 1'b1;
      end
    end
  end

  // command outputs, all registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_fwd_o <= 1'b0;
      run_rev_o <= 1'b0;
      stop_req_o <= 1'b0;
      stop_method_o <= 2'b00;
      setting_conflict_error_o <= 1'b0;
      drive_disabled_indication_o <= 1'b0;
      dc_brake_o <= 1'b0;
    end else begin
      run_fwd_o <= running_reg & ~dir_rev;
      run_rev_o <= running_reg & dir_rev;
      stop_req_o <= ~running_reg;
      stop_method_o <= ctrl_reg[CTRL_STOP_LSB +: 2];
      setting_conflict_error_o <= conflict;
      drive_disabled_indication_o <= ~enabled;
      // brake only while stopped, run or jog ends it
      dc_brake_o <= fn.dcbrk & ~running_reg & ~any_run & ~jog;
    end
  end

  // pid and auxiliary function outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pid_int_reset_o <= 1'b0;
      pid_int_hold_o <= 1'b0;
      pid_soft_cancel_o <= 1'b0;
      pid_sign_inv_o <= 1'b0;
      step_sel4_o <= 1'b0;
      offset_sel_o <= 3'b000;
      search_en_o <= 1'b0;
      kinetic_buffer_decel_o <= 1'b0;
      torque_mode_o <= 1'b0;
      bias_up_o <= 1'b0;
      bias_dn_o <= 1'b0;
    end else begin
      pid_int_reset_o <= fn.pid_irst;
      pid_int_hold_o <= fn.pid_ihold;
      pid_soft_cancel_o <= fn.soft_can;
      pid_sign_inv_o <= fn.pid_sign;
      step_sel4_o <= fn.step4;
      offset_sel_o <= fn.ofs;
      search_en_o <= fn.srch | ctrl_reg[CTRL_SRCH_BIT];
      kinetic_buffer_decel_o <= fn.kinetic_buffer_decel & ~conflict;
      // torque when closed, mode setting zero only
      torque_mode_o <= fn.trq & (ctrl_reg[CTRL_MODE_LSB +: 2] == 2'b00);
      // bias moves only when paired, both hold
      bias_up_o <= fn.bias_up & ~fn.bias_dn & asg.bias_dn;
      bias_dn_o <= fn.bias_dn & ~fn.bias_up & asg.bias_up;
    end
  end

  dif_loop_test dif_loop_test_inst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(fn.comtest),
    .pat_i(pat_reg),
    .rx_i(rx_reg),
    .tx_o(lt_tx),
    .busy_o(lt_busy),
    .pass_o(lt_pass),
    .fail_o(lt_fail)
  );

  // transmit line registered at the top
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_o <= 1'b1;
    end else begin
      tx_o <= lt_tx;
    end
  end
endmodule

/* tb/dif_far_end.sv */
/*
  far-side model: the switches on the terminals and the loop wire on the serial port.
  assumes the bench sets the levels; brk_i models a faulty loop.
*/
`timescale 1ns/100ps
module dif_far_end (
  input wire logic [7:0] lvl_i, // wanted switch levels
  input wire logic brk_i, // 1 = loop wire faulty
  input wire logic tx_i, // device transmit
  output logic [7:0] term_o, // terminal pins
  output logic rx_o // device receive
);
  // switches drive the pins directly
  assign term_o = lvl_i;
  // loop tx back
  // a faulty loop inverts, so a stale bit never passes
  assign rx_o = brk_i ? ~tx_i : tx_i;
endmodule

/* tb/dif_decoder_props.sv */
/*
  checker on the decoder ports: bus answer, run, fault and brake relations.
  assumes one clock and synchronous active-high reset.
*/
`timescale 1ns/100ps
module dif_decoder_props
  import dif_pkg::*;
#(
  parameter int NTERM = DIF_NTERM // terminal count
) (
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write
  input wire logic wb_ack_o, // ack
  input wire logic run_fwd_o, // forward
  input wire logic run_rev_o, // reverse
  input wire logic stop_req_o, // stop
  input wire logic ext_fault_o, // fault
  input wire logic drive_disabled_indication_o, // disabled
  input wire logic dc_brake_o, // brake
  input wire logic tx_o // transmit
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // request taken and its one-cycle answer
  sequence wb_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence wb_answer;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_next_cycle:
    assert property (wb_take |=> wb_answer) else $error("ack not one cycle after request");
  a_reset_idle:
    assert property (disable iff (1'b0) rst_i |=> tx_o && !wb_ack_o && !run_fwd_o)
    else $error("outputs not idle in reset");
  a_dir_exclusive:
    assert property (!(run_fwd_o && run_rev_o)) else $error("both directions");
  a_fault_sticky:
    assert property (ext_fault_o && !wb_we_i && !$past(wb_we_i) |=> ext_fault_o)
    else $error("fault dropped without clear");
  a_fault_stops:
    assert property (ext_fault_o |=> !run_fwd_o && !run_rev_o) else $error("run with fault");
  a_disabled_norun:
    assert property (drive_disabled_indication_o |=> !run_fwd_o && !run_rev_o)
    else $error("run while disabled");
  a_run_not_stop:
    assert property (run_fwd_o || run_rev_o |-> !stop_req_o) else $error("stop while running");
  a_brake_stopped:
    assert property (dc_brake_o |-> !run_fwd_o && !run_rev_o) else $error("brake while running");
endmodule
bind dif_decoder dif_decoder_props #(.NTERM(NTERM)) dif_decoder_props_inst (.clk_i, .rst_i,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o, .run_fwd_o, .run_rev_o, .stop_req_o,
  .ext_fault_o, .drive_disabled_indication_o, .dc_brake_o, .tx_o);

/* tb/dif_decoder_tb.sv */
/*
  testbench: wishbone register access and terminal patterns against the decoder.
  assumes the far-side model drives the terminals and loops the serial port.
*/
`timescale 1ns/100ps
module dif_decoder_tb
  import dif_pkg::*;
;
  logic clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, rx_i, brk;
  logic [7:0] term_i, lvl, wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [3:0] wb_sel_i;
  logic [1:0] stop_method_o;
  logic [2:0] offset_sel_o;
  logic wb_ack_o, run_fwd_o, run_rev_o, stop_req_o, ext_fault_o, setting_conflict_error_o;
  logic drive_disabled_indication_o, pid_int_reset_o, pid_int_hold_o, pid_soft_cancel_o;
  logic pid_sign_inv_o, step_sel4_o, dc_brake_o, search_en_o, kinetic_buffer_decel_o;
  logic torque_mode_o, bias_up_o, bias_dn_o, tx_o;
  int n_fail, cmp_count;
  // bad assignment pairs: 2-wire mix, two searches, two ride-throughs, lone bias
  localparam logic [31:0] CF_LO [4] = '{32'h0000_4240, 32'h0, 32'h0, 32'h0};
  localparam logic [31:0] CF_HI [4] = '{32'h0, 32'h0000_6261, 32'h0000_6665, 32'h0000_0075};

  dif_decoder dif_decoder_inst (.*);
  dif_far_end dif_far_end_inst (.lvl_i(lvl), .brk_i(brk), .tx_i(tx_o), .term_o(term_i),
    .rx_o(rx_i));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task stop_test;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one classic cycle; held until ack is sampled, data taken at that edge
  task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_fail++;
      stop_test;
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  // new switch levels, then wait past the 4-edge path
  task put(input logic [7:0] v);
    @(posedge clk_i);
    lvl <= v;
    repeat (5) @(posedge clk_i);
  endtask

  task cfg(input logic [31:0] lo, input logic [31:0] hi);
    wb(DIF_FSEL_LO, 1'b1, lo);
    wb(DIF_FSEL_HI, 1'b1, hi);
  endtask

  // status polling is bounded; a missing flag shows as a mismatch
  task poll(input int b);
    int n;
    n = 0;
    do begin
      wb(DIF_STAT, 1'b0, 32'h0);
      n++;
    end while (q[b] !== 1'b1 && n < 100);
    chk("test flag", {31'h0, q[b]}, 32'h1);
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    stop_test;
  end

  initial begin
    rst_i = 1'b1;
    lvl = 8'h00;
    brk = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'hF;
    n_fail = 0;
    cmp_count = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("idle", {tx_o, stop_req_o}, 2'b11);
    wb(DIF_FSEL_HI, 1'b0, 32'h0);
    chk("fsel reset", q, DIF_FSEL_RST);
    wb(DIF_LOOP, 1'b0, 32'h0);
    chk("loop reset", q, {24'h0, DIF_LOOP_PAT_RST});
    wb(8'h3C, 1'b0, 32'h0);
    chk("unmapped", q, 32'h0);
    // 2-wire fwd/rev plus pid, step and offset terminals
    cfg(32'h3532_4140, 32'h3444_3130);
    wb(DIF_CTRL, 1'b1, 32'h0000_0001);
    put(8'h01);
    chk("fwd", {run_fwd_o, run_rev_o, stop_req_o}, 3'b100);
    put(8'h02);
    chk("rev", {run_fwd_o, run_rev_o, stop_req_o}, 3'b010);
    put(8'h03);
    chk("both", {ext_fault_o, run_fwd_o, run_rev_o}, 3'b100);
    put(8'h00);
    chk("sticky", {ext_fault_o, stop_method_o}, 3'b101);
    wb(DIF_CTRL, 1'b1, 32'h0000_0021);
    wb(DIF_STAT, 1'b0, 32'h0);
    chk("fault clear", {q[11], q[7:0]}, 9'h0);
    put(8'hFC);
    chk("pid on", {pid_int_reset_o, pid_int_hold_o, step_sel4_o, pid_sign_inv_o,
      pid_soft_cancel_o, offset_sel_o}, 8'hF9);
    put(8'h00);
    chk("pid off", {pid_int_reset_o, pid_int_hold_o, step_sel4_o, pid_sign_inv_o,
      pid_soft_cancel_o, offset_sel_o}, 8'h00);
    // run/direction, brake, enable, search, ride-through, bias pair
    cfg(32'h6A60_4342, 32'h7675_6661);
    put(8'h01);
    chk("disabled", {drive_disabled_indication_o, run_fwd_o}, 2'b10);
    put(8'h09);
    chk("held run", {drive_disabled_indication_o, run_fwd_o}, 2'b00);
    put(8'h08);
    put(8'h09);
    chk("run2", {run_fwd_o, run_rev_o}, 2'b10);
    put(8'h0B);
    chk("dir2", {run_fwd_o, run_rev_o}, 2'b01);
    put(8'h03);
    chk("en open", {run_rev_o, stop_req_o, drive_disabled_indication_o}, 3'b011);
    put(8'h0C);
    chk("brake", dc_brake_o, 1'b1);
    wb(DIF_CMD, 1'b1, 32'h0000_0002);
    put(8'h0C);
    chk("jog", dc_brake_o, 1'b0);
    wb(DIF_CMD, 1'b1, 32'h0);
    put(8'h0D);
    chk("brake end", {dc_brake_o, run_fwd_o}, 2'b01);
    put(8'h78);
    chk("misc on", {search_en_o, kinetic_buffer_decel_o, bias_up_o, bias_dn_o,
      setting_conflict_error_o}, 5'b11100);
    put(8'hB8);
    chk("bias down", {bias_up_o, bias_dn_o}, 2'b01);
    // both closed holds the bias
    put(8'hF8);
    chk("bias both", {bias_up_o, bias_dn_o}, 2'b00);
    put(8'h08);
    chk("misc off", {search_en_o, kinetic_buffer_decel_o}, 2'b00);
    for (int i = 0; i < 4; i++) begin
      cfg(CF_LO[i], CF_HI[i]);
      put(8'h00);
      chk("conflict", setting_conflict_error_o, 1'b1);
    end
    // speed/torque switch, then a nonzero control mode
    cfg(32'h0, 32'h0000_0071);
    put(8'h10);
    chk("torque", {torque_mode_o, setting_conflict_error_o}, 2'b10);
    put(8'h00);
    chk("speed", torque_mode_o, 1'b0);
    // software run when no 2-wire codes are assigned
    wb(DIF_CMD, 1'b1, 32'h0000_0001);
    put(8'h00);
    chk("sw run", {run_fwd_o, stop_req_o}, 2'b10);
    wb(DIF_CMD, 1'b1, 32'h0);
    wb(DIF_CTRL, 1'b1, 32'h0000_0004);
    put(8'h00);
    chk("mode conflict", setting_conflict_error_o, 1'b1);
    wb(DIF_CTRL, 1'b1, 32'h0);
    // loopback test, good wire then faulty wire
    cfg(32'h0, 32'h0000_0067);
    put(8'h10);
    poll(14);
    put(8'h00);
    brk <= 1'b1;
    put(8'h10);
    poll(15);
    stop_test;
  end
endmodule
